// >>> core/cantbs_cfg.svh
`ifndef CANTBS_CFG_SVH
`define CANTBS_CFG_SVH
`define CANTBS_NBUF        3
`define CANTBS_BUF_BYTES   14
`define CANTBS_BUF_STRIDE  16
`define CANTBS_CTRL_ADDR0  8'h30
`define CANTBS_CTRL_ADDR1  8'h40
`define CANTBS_CTRL_ADDR2  8'h50
`define CANTBS_PINCTL_ADDR 8'h0D
`define CANTBS_BIT_ABORTED_FLAG    6
`define CANTBS_BIT_LOST_ARBITRATION_FLAG    5
`define CANTBS_BIT_SEND_ERROR_FLAG   4
`define CANTBS_BIT_REQ     3
`define CANTBS_PRIO_HI     1
`define CANTBS_PRIO_LO     0
`define CANTBS_RTSM_LO     0
`define CANTBS_RTSM_HI     2
`define CANTBS_RTS_LO      3
`define CANTBS_RTS_HI      5
`define CANTBS_BYTE_RESET  8'h00
`define CANTBS_CTRL_RESET  8'h00
`endif

// >>> core/cantbs_pkg.sv
package cantbs_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
  } cantbs_wr_t;
  typedef struct packed {
    logic       done;
    logic       err;
    logic       lost;
  } cantbs_evt_t;
  typedef enum logic [1:0] {
    CANTBS_IDLE = 2'b00,
    CANTBS_SEND = 2'b01
  } cantbs_state_t;
endpackage

// >>> core/cantbs_top.sv
`timescale 1ns/100ps
`include "cantbs_cfg.svh"
// What this block does
// - three transmit buffers, fourteen bytes each: control, five id bytes, eight data.
// - before start of frame the highest priority queued buffer is chosen.
// - equal priority goes to the larger buffer number.
// - priority field 11 highest down to 00 lowest.
// - request set by host write or request pin; write may set priority too.
// - setting a request clears aborted, lost-arbitration and error flags.
// - request only marks ready; sending starts when the bus is available.
// - success clears request and pulses the done event for the interrupt logic.
// - error keeps request, sets error flag and pulses message-error event.
// - lost arbitration keeps request and sets the lost-arbitration flag.
// - request pin is digital input or trigger; falling edge sets request.
// - pin control register writes accepted only in configuration mode.
// - host clearing a request aborts it without setting the aborted flag.
// - abort-all bit aborts every pending message not yet begun until host clears it.
// - aborted flag set only by abort-all aborts.
// - once sending began, host clears of the request are ignored.
// - begun message hitting error or lost arbitration retries despite abort.
// - control bytes at addresses 30h, 40h and 50h.
module cantbs_top
(
  input  wire logic                 core_clk,
  input  wire logic                 resetn,
  input  wire cantbs_pkg::cantbs_wr_t host_wr,
  input  wire logic [7:0]           host_raddr,
  output logic [7:0]                host_rdata,
  input  wire logic                 config_mode,
  input  wire logic                 abort_all_bit,
  input  wire logic [2:0]           send_request_pin_n,
  input  wire logic                 bus_available,
  output logic                      start_frame,
  output logic [1:0]                send_buffer_index,
  input  wire cantbs_pkg::cantbs_evt_t engine_evt,
  output logic [2:0]                send_done_flag_set,
  output logic                      message_error_flag_set
);

  logic [7:0]                 buf_mem_q [`CANTBS_NBUF][`CANTBS_BUF_BYTES];
  logic [2:0]                 req_q;
  logic [1:0]                 prio_q [`CANTBS_NBUF];
  logic [2:0]                 aborted_flag_q;
  logic [2:0]                 lost_arbitration_flag_q;
  logic [2:0]                 send_error_flag_q;
  logic [2:0]                 rtsm_q;
  logic [2:0]                 pin_q;
  logic [2:0]                 pin_fall;
  cantbs_pkg::cantbs_state_t  state_q;
  logic [1:0]                 cur_q;
  logic                       start_q;
  logic [2:0]                 done_q;
  logic                       merr_q;
  logic [1:0]                 win;
  logic                       any_req;
  logic [2:0]                 host_set;
  logic [2:0]                 host_clr;
  logic [2:0]                 begun_q;

  function automatic logic [1:0] ctrl_index(input logic [7:0] a, output logic hit);
    hit = 1'b1;
    ctrl_index = 2'd0;
    if (a == `CANTBS_CTRL_ADDR0)
      ctrl_index = 2'd0;
    else if (a == `CANTBS_CTRL_ADDR1)
      ctrl_index = 2'd1;
    else if (a == `CANTBS_CTRL_ADDR2)
      ctrl_index = 2'd2;
    else
      hit = 1'b0;
  endfunction

  function automatic logic [7:0] ctrl_read(input int i);
    ctrl_read = `CANTBS_CTRL_RESET;
    ctrl_read[`CANTBS_BIT_ABORTED_FLAG]  = aborted_flag_q[i];
    ctrl_read[`CANTBS_BIT_LOST_ARBITRATION_FLAG]  = lost_arbitration_flag_q[i];
    ctrl_read[`CANTBS_BIT_SEND_ERROR_FLAG] = send_error_flag_q[i];
    ctrl_read[`CANTBS_BIT_REQ]   = req_q[i];
    ctrl_read[`CANTBS_PRIO_HI:`CANTBS_PRIO_LO] = prio_q[i];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // host write decode
  always_comb
  begin
    host_set = 3'h0;
    host_clr = 3'h0;
    for (int i = 0; i < `CANTBS_NBUF; i++)
    begin
      if (host_wr.wr && host_wr.addr == `CANTBS_CTRL_ADDR0 + 8'(`CANTBS_BUF_STRIDE * i))
      begin
        host_set[i] = host_wr.wdata[`CANTBS_BIT_REQ];
        host_clr[i] = ~host_wr.wdata[`CANTBS_BIT_REQ];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer storage, writable only while the buffer's request is clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `CANTBS_NBUF; i++)
        for (int j = 0; j < `CANTBS_BUF_BYTES; j++)
          buf_mem_q[i][j] <= `CANTBS_BYTE_RESET;
    end
    else if (host_wr.wr)
    begin
      for (int i = 0; i < `CANTBS_NBUF; i++)
        for (int j = 1; j < `CANTBS_BUF_BYTES; j++)
          if (host_wr.addr == `CANTBS_CTRL_ADDR0 + 8'(`CANTBS_BUF_STRIDE * i + j)
              && !req_q[i])
            buf_mem_q[i][j] <= host_wr.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request pins
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rtsm_q <= 3'h0;
    else if (host_wr.wr && host_wr.addr == `CANTBS_PINCTL_ADDR && config_mode)
      rtsm_q <= host_wr.wdata[`CANTBS_RTSM_HI:`CANTBS_RTSM_LO];
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pin_q <= 3'h7;
    else
      pin_q <= send_request_pin_n;
  end

  assign pin_fall = pin_q & ~send_request_pin_n & rtsm_q;

  ////////////////////////////////////////////////////////////////////////////
  // priority selection
  always_comb
  begin
    win = 2'd0;
    any_req = 1'b0;
    for (int i = 0; i < `CANTBS_NBUF; i++)
    begin
      if (req_q[i] && (!abort_all_bit || begun_q[i])
          && (!any_req || prio_q[i] >= prio_q[win]))
      begin
        win = 2'(i);
        any_req = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scheduler
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= cantbs_pkg::CANTBS_IDLE;
      cur_q <= 2'd0;
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= 1'b0;
      unique case (state_q)
        cantbs_pkg::CANTBS_IDLE:
          if (any_req && bus_available)
          begin
            state_q <= cantbs_pkg::CANTBS_SEND;
            cur_q <= win;
            start_q <= 1'b1;
          end
        cantbs_pkg::CANTBS_SEND:
          if (engine_evt.done || engine_evt.err || engine_evt.lost)
            state_q <= cantbs_pkg::CANTBS_IDLE;
        default:
          state_q <= cantbs_pkg::CANTBS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and status flags
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_q <= 3'h0;
      aborted_flag_q <= 3'h0;
      lost_arbitration_flag_q <= 3'h0;
      send_error_flag_q <= 3'h0;
      done_q <= 3'h0;
      merr_q <= 1'b0;
      begun_q <= 3'h0;
      for (int i = 0; i < `CANTBS_NBUF; i++)
        prio_q[i] <= 2'b00;
    end
    else
    begin
      done_q <= 3'h0;
      merr_q <= 1'b0;
      for (int i = 0; i < `CANTBS_NBUF; i++)
      begin
        logic busy;
        busy = (state_q == cantbs_pkg::CANTBS_SEND) && (cur_q == 2'(i));
        if (host_wr.wr && host_wr.addr == `CANTBS_CTRL_ADDR0 + 8'(`CANTBS_BUF_STRIDE * i)
            && !busy)
          prio_q[i] <= host_wr.wdata[`CANTBS_PRIO_HI:`CANTBS_PRIO_LO];
        if (busy && engine_evt.done)
          begun_q[i] <= 1'b0;
        else if (start_q && cur_q == 2'(i))
          begun_q[i] <= 1'b1;
        if (busy && engine_evt.done)
        begin
          req_q[i] <= 1'b0;
          done_q[i] <= 1'b1;
        end
        else if (busy && engine_evt.err)
        begin
          send_error_flag_q[i] <= 1'b1;
          merr_q <= 1'b1;
        end
        else if (busy && engine_evt.lost)
          lost_arbitration_flag_q[i] <= 1'b1;
        else if (!busy && (host_set[i] || pin_fall[i]) && !req_q[i])
        begin
          req_q[i] <= 1'b1;
          aborted_flag_q[i] <= 1'b0;
          lost_arbitration_flag_q[i] <= 1'b0;
          send_error_flag_q[i] <= 1'b0;
        end
        else if (!busy && !begun_q[i] && req_q[i] && abort_all_bit)
        begin
          req_q[i] <= 1'b0;
          aborted_flag_q[i] <= 1'b1;
        end
        else if (!busy && !begun_q[i] && host_clr[i])
          req_q[i] <= 1'b0;
      end
    end
  end

  // begun messages stay pending through aborts and retry after error or lost arbitration

  ////////////////////////////////////////////////////////////////////////////
  // outputs and read
  assign start_frame = start_q;
  assign send_buffer_index = cur_q;
  assign send_done_flag_set = done_q;
  assign message_error_flag_set = merr_q;

  always_comb
  begin
    logic       hit;
    logic [1:0] idx;
    hit = 1'b0;
    idx = ctrl_index(host_raddr, hit);
    host_rdata = `CANTBS_BYTE_RESET;
    if (hit)
      host_rdata = ctrl_read(int'(idx));
    else if (host_raddr == `CANTBS_PINCTL_ADDR)
      host_rdata = {2'b00, send_request_pin_n, rtsm_q};
    else
      for (int i = 0; i < `CANTBS_NBUF; i++)
        for (int j = 1; j < `CANTBS_BUF_BYTES; j++)
          if (host_raddr == `CANTBS_CTRL_ADDR0 + 8'(`CANTBS_BUF_STRIDE * i + j))
            host_rdata = buf_mem_q[i][j];
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_done_clears_req: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_q == cantbs_pkg::CANTBS_SEND && engine_evt.done) |=> !req_q[cur_q])
    else $error("request not cleared on success");
  a_err_keeps_req: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_q == cantbs_pkg::CANTBS_SEND && engine_evt.err && !engine_evt.done)
    |=> req_q[$past(cur_q)] && send_error_flag_q[$past(cur_q)] && merr_q)
    else $error("error did not keep request");
  a_lost_flag: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_q == cantbs_pkg::CANTBS_SEND && engine_evt.lost && !engine_evt.done
     && !engine_evt.err) |=> lost_arbitration_flag_q[$past(cur_q)] && req_q[$past(cur_q)])
    else $error("lost arbitration not recorded");
  a_start_needs_bus: assert property (@(posedge core_clk) disable iff (!resetn)
    start_q |-> $past(bus_available) && $past(any_req))
    else $error("start without bus or request");
  a_start_prio: assert property (@(posedge core_clk) disable iff (!resetn)
    start_q |-> $past(prio_q[0]) <= $past(prio_q[win]) || !$past(req_q[0]))
    else $error("lower priority buffer chosen");
  a_begun_kept: assert property (@(posedge core_clk) disable iff (!resetn)
    (begun_q[0] && !engine_evt.done) |=> req_q[0])
    else $error("begun request dropped");
  a_pinctl_lock: assert property (@(posedge core_clk) disable iff (!resetn)
    !config_mode |=> $stable(rtsm_q))
    else $error("pin control changed outside configuration");
  a_busy_no_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    (state_q == cantbs_pkg::CANTBS_SEND && !engine_evt.done)
    |=> req_q[$past(cur_q)])
    else $error("busy request cleared");
  a_aborted_flag_cause: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(aborted_flag_q[0]) |-> $past(abort_all_bit))
    else $error("aborted flag without abort-all");

endmodule

// >>> testbench/cantbs_engine_model.sv
`timescale 1ns/100ps
// bit engine stand-in: one result pulse eight cycles after each start
module cantbs_engine_model
(
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               start_frame,
  input  wire logic [1:0]         result_sel,
  output cantbs_pkg::cantbs_evt_t engine_evt
);
  logic [3:0] wait_q;
  logic       busy_q;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_q     <= 1'b0;
      wait_q     <= 4'h0;
      engine_evt <= '0;
    end
    else
    begin
      engine_evt <= '0;
      if (start_frame)
      begin
        busy_q <= 1'b1;
        wait_q <= 4'h6;
      end
      else if (busy_q && wait_q != 4'h0)
        wait_q <= wait_q - 4'h1;
      else if (busy_q)
      begin
        busy_q     <= 1'b0;
        engine_evt <= {result_sel == 2'h0, result_sel == 2'h1, result_sel == 2'h2};
      end
    end
  end
endmodule

// >>> testbench/cantbs_top_test.sv
`timescale 1ns/100ps
module cantbs_top_test;
  logic                    core_clk = 1'b0;
  logic                    resetn = 1'b0;
  cantbs_pkg::cantbs_wr_t  host_wr = '0;
  logic [7:0]              host_raddr = 8'h00;
  logic [7:0]              host_rdata;
  logic                    config_mode = 1'b0;
  logic                    abort_all_bit = 1'b0;
  logic [2:0]              send_request_pin_n = 3'h7;
  logic                    bus_available = 1'b0;
  logic                    start_frame;
  logic [1:0]              send_buffer_index;
  cantbs_pkg::cantbs_evt_t engine_evt;
  logic [2:0]              send_done_flag_set;
  logic                    message_error_flag_set;
  logic [1:0]              result_sel = 2'h0;
  logic [2:0]              done_seen = 3'h0;
  logic                    merr_seen = 1'b0;
  logic                    clr_seen = 1'b0;
  logic [7:0]              starts = 8'h00;
  logic [7:0]              p;
  int                      mismatches = 0;
  int                      tests_run = 0;
  // rows: winner index, then priority of buffer 2, 1, 0
  logic [7:0]              rows [6] = '{8'h1B, 8'hA4, 8'h5A, 8'h95, 8'hBC, 8'hA2};
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    done_seen <= clr_seen ? 3'h0 : (done_seen | send_done_flag_set);
    merr_seen <= merr_seen | message_error_flag_set;
    starts    <= clr_seen ? 8'h00 : (starts + {7'h00, start_frame});
  end
  cantbs_top cantbs_top_inst (.core_clk(core_clk), .resetn(resetn), .host_wr(host_wr),
    .host_raddr(host_raddr), .host_rdata(host_rdata), .config_mode(config_mode),
    .abort_all_bit(abort_all_bit), .send_request_pin_n(send_request_pin_n),
    .bus_available(bus_available), .start_frame(start_frame),
    .send_buffer_index(send_buffer_index), .engine_evt(engine_evt),
    .send_done_flag_set(send_done_flag_set), .message_error_flag_set(message_error_flag_set));
  cantbs_engine_model cantbs_engine_model_inst (.core_clk(core_clk), .resetn(resetn),
    .start_frame(start_frame), .result_sel(result_sel), .engine_evt(engine_evt));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_wr <= '{addr: a, wdata: d, wr: 1'b1};
    @(posedge core_clk);
    host_wr.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    host_raddr <= a;
    @(negedge core_clk);
    chk($sformatf("byte %h", a), exp, host_rdata);
    @(posedge core_clk);
  endtask
  // 0 start, 1 done pulse, 2 lost result, 3 message error pulse
  task automatic await(input int k);
    int n;
    n = 0;
    while (!((k == 0 && start_frame === 1'b1) || (k == 1 && done_seen !== 3'h0)
        || (k == 2 && engine_evt.lost === 1'b1) || (k == 3 && merr_seen === 1'b1)) && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    if (n >= 100)
    begin
      mismatches++;
      $display("ERROR wait %0d expected event seen none", k);
      stop_test();
    end
  endtask
  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    for (int r = 0; r < 6; r++)
    begin
      for (int b = 0; b < 3; b++)
        wr(8'h30 + 8'(b) * 8'h10, 8'h08 | ((rows[r] >> (2 * b)) & 8'h03));
      for (int b = 0; b < 3; b++)
        rd(8'h30 + 8'(b) * 8'h10, 8'h08 | ((rows[r] >> (2 * b)) & 8'h03));
      chk("early starts", 8'h00, starts);
      @(posedge core_clk);
      bus_available <= 1'b1;
      await(0);
      chk("index", {6'h00, rows[r][7:6]}, {6'h00, send_buffer_index});
      @(posedge core_clk);
      bus_available <= 1'b0;
      abort_all_bit <= 1'b1;
      await(1);
      chk("done", 8'h01 << rows[r][7:6], {5'h00, done_seen});
      for (int b = 0; b < 3; b++)
      begin
        p = (rows[r] >> (2 * b)) & 8'h03;
        rd(8'h30 + 8'(b) * 8'h10, (b == rows[r][7:6]) ? p : (8'h40 | p));
      end
      @(posedge core_clk);
      abort_all_bit <= 1'b0;
      clr_seen <= 1'b1;
      @(posedge core_clk);
      clr_seen <= 1'b0;
    end
    wr(8'h31, 8'hA5);
    rd(8'h31, 8'hA5);
    wr(8'h5D, 8'h3C);
    rd(8'h5D, 8'h3C);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h0B);
    wr(8'h31, 8'h5A);
    rd(8'h31, 8'hA5);
    wr(8'h30, 8'h00);
    rd(8'h30, 8'h00);
    @(posedge core_clk);
    send_request_pin_n <= 3'h6;
    rd(8'h0D, 8'h30);
    rd(8'h30, 8'h00);
    send_request_pin_n <= 3'h7;
    wr(8'h0D, 8'h07);
    rd(8'h0D, 8'h38);
    config_mode <= 1'b1;
    wr(8'h0D, 8'h07);
    rd(8'h0D, 8'h3F);
    send_request_pin_n <= 3'h3;
    rd(8'h0D, 8'h1F);
    rd(8'h50, 8'h0A);
    send_request_pin_n <= 3'h7;
    config_mode <= 1'b0;
    wr(8'h50, 8'h00);
    result_sel <= 2'h1;
    wr(8'h40, 8'h0B);
    bus_available <= 1'b1;
    await(3);
    result_sel <= 2'h2;
    rd(8'h40, 8'h1B);
    chk("restarts", 8'h02, starts);
    bus_available <= 1'b0;
    wr(8'h40, 8'h00);
    await(2);
    rd(8'h40, 8'h3B);
    wr(8'h40, 8'h03);
    rd(8'h40, 8'h3B);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd(8'h40, 8'h00);
    rd(8'h0D, 8'h38);
    rd(8'h20, 8'h00);
    stop_test();
  end
endmodule
